/* design/ddrp_device.sv */
// Operation
// - Activate latches all thirteen row address bits
// - Column on A0-A8, A10 selects auto-precharge
// - Two bank bits select target bank
// - ODT sampled high enables termination
// - Device drives strobe on reads only
// - Read strobe edges coincide with data
// - Lower strobe times DQ0-DQ7 only
// - Upper strobe times DQ8-DQ15 only
// - Complement strobes used only in differential mode
// - Chip select high ignores the command
// - Command decoded from CS, RAS, CAS, WE
// - Masked write bytes are not stored
// - Mask sampled on both strobe edges
// - Command, CKE and ODT inputs sampled only at clock rise
// - Read data on both clock edges
// - Clock enable gates internal clocking
// - Read latency equals AL plus CL
// - Bursts are four or eight beats
`timescale 1ns/1ps
`include "ddrp_cfg.svh"

module ddrp_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk_in,       // System clock
  input  wire logic         reset_n_in,   // Synchronous reset
  input  wire logic         in_valid_in,  // Write request
  output logic              in_ready_out, // Room available
  input  wire logic [W-1:0] in_data_in,   // Write data
  output logic              out_valid_out,// Data available
  input  wire logic         out_ready_in, // Read request
  output logic [W-1:0]      out_data_out  // Head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("FIFO depth must be a power of two of at least two");
  end

  assign in_ready_out  = (count_reg != D[AW:0]);
  assign out_valid_out = (count_reg != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;
  assign out_data_out  = mem[rd_ptr_reg];

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module ddrp_device #(
  parameter int ROW_BITS = 2,   // Row bits backed by storage
  parameter int COL_BITS = 5    // Column bits backed by storage
) (
  input  wire logic        clk_sys_in,     // 100 MHz system clock
  input  wire logic        reset_n_in,     // Synchronous reset, active low
  input  wire logic        ck_in,          // Memory clock from controller
  input  wire logic        cke_in,         // Clock enable
  input  wire logic        cs_n_in,        // Chip select
  input  wire logic        ras_n_in,       // Row strobe
  input  wire logic        cas_n_in,       // Column strobe
  input  wire logic        we_n_in,        // Write enable
  input  wire logic [1:0]  ba_in,          // Bank select
  input  wire logic [12:0] addr_in,        // Address
  input  wire logic        odt_in,         // Termination control
  input  wire logic [1:0]  dm_in,          // Byte write masks
  input  wire logic [15:0] dq_in,          // Data pins, input side
  output logic      [15:0] dq_out,         // Data pins, output side
  output logic      [15:0] dq_oe_n_out,    // Data drive enable, low drives
  input  wire logic [1:0]  dqs_in,         // Byte strobes, input side
  output logic      [1:0]  dqs_out,        // Byte strobes, output side
  output logic      [1:0]  dqs_oe_n_out,   // Strobe drive enable, low drives
  output logic      [1:0]  dqs_n_out,      // Complement strobes, output side
  output logic      [1:0]  dqs_n_oe_n_out, // Complement drive enable, low drives
  output logic             odt_on_out,     // Termination switched on
  output logic             clk_on_out      // Internal clocking active
);
  localparam int MAW = 2 + ROW_BITS + COL_BITS;

  if (ROW_BITS < 1 || ROW_BITS > `DDRP_ROW_W || COL_BITS < 3 || COL_BITS > `DDRP_COL_W)
  begin : g_chk
    $error("Storage row or column width out of range");
  end

  ddrp_pkg::ddrp_cmd_s cmd_s1_reg;
  ddrp_pkg::ddrp_cmd_s cmd_s2_reg;
  logic [2:0]  ck_sync_reg;
  logic [1:0]  cke_sync_reg;
  logic [1:0]  odt_sync_reg;
  logic [1:0]  dm_s1_reg;
  logic [1:0]  dm_s2_reg;
  logic [15:0] dq_s1_reg;
  logic [15:0] dq_s2_reg;
  logic [1:0]  dqs_s1_reg;
  logic [1:0]  dqs_s2_reg;
  logic [1:0]  dqs_s3_reg;

  // Two flops on every pin; the third ck and dqs flops only feed edge detection
  always_ff @(posedge clk_sys_in)
  begin
    cmd_s1_reg   <= {cs_n_in, ras_n_in, cas_n_in, we_n_in, ba_in, addr_in};
    cmd_s2_reg   <= cmd_s1_reg;
    ck_sync_reg  <= {ck_sync_reg[1:0], ck_in};
    cke_sync_reg <= {cke_sync_reg[0], cke_in};
    odt_sync_reg <= {odt_sync_reg[0], odt_in};
    dm_s1_reg    <= dm_in;
    dm_s2_reg    <= dm_s1_reg;
    dq_s1_reg    <= dq_in;
    dq_s2_reg    <= dq_s1_reg;
    dqs_s1_reg   <= dqs_in;
    dqs_s2_reg   <= dqs_s1_reg;
    dqs_s3_reg   <= dqs_s2_reg;
  end

  logic ck_rise;
  logic ck_fall;
  assign ck_rise = ck_sync_reg[1] && !ck_sync_reg[2];
  assign ck_fall = !ck_sync_reg[1] && ck_sync_reg[2];

  logic clk_on_reg;
  logic odt_reg;
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      clk_on_reg <= 1'b0;
      odt_reg    <= 1'b0;
    end
    else if (ck_rise)
    begin
      clk_on_reg <= cke_sync_reg[1];
      odt_reg    <= odt_sync_reg[1];
    end
  end
  assign clk_on_out = clk_on_reg;
  assign odt_on_out = odt_reg;

  // Command decode; the chip select gates the command but is not part of the command code
  logic [2:0] cmd_code;
  logic       cmd_ok;
  logic       act_take;
  logic       rd_take;
  logic       wr_take;
  logic       pre_take;
  logic       mrs_take;
  ddrp_pkg::ddrp_rd_e rd_state_reg;
  logic       wr_act_reg;
  logic       port_idle;
  logic [3:0] bank_open_reg;
  logic [12:0] bank_row_reg [4];
  assign cmd_code  = {cmd_s2_reg.ras_n, cmd_s2_reg.cas_n, cmd_s2_reg.we_n};
  assign cmd_ok    = ck_rise && clk_on_reg && !cmd_s2_reg.cs_n;
  assign port_idle = (rd_state_reg == ddrp_pkg::RD_IDLE) && !wr_act_reg;
  assign act_take  = cmd_ok && (cmd_code == `DDRP_CMD_ACT);
  assign pre_take  = cmd_ok && (cmd_code == `DDRP_CMD_PRE);
  assign mrs_take  = cmd_ok && (cmd_code == `DDRP_CMD_MRS);
  // Accesses to a closed bank or while a burst runs are dropped
  assign rd_take   = cmd_ok && (cmd_code == `DDRP_CMD_RD) && port_idle
                     && bank_open_reg[cmd_s2_reg.ba];
  assign wr_take   = cmd_ok && (cmd_code == `DDRP_CMD_WR) && port_idle
                     && bank_open_reg[cmd_s2_reg.ba];

  // Bank state; auto-precharge closes at command time since reopening needs an activate
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      bank_open_reg <= 4'h0;
    end
    else if (act_take)
    begin
      bank_open_reg[cmd_s2_reg.ba] <= 1'b1;
      bank_row_reg[cmd_s2_reg.ba]  <= cmd_s2_reg.addr;
    end
    else if (pre_take)
    begin
      if (cmd_s2_reg.addr[`DDRP_AP_BIT])
      begin
        bank_open_reg <= 4'h0;
      end
      else
      begin
        bank_open_reg[cmd_s2_reg.ba] <= 1'b0;
      end
    end
    else if ((rd_take || wr_take) && cmd_s2_reg.addr[`DDRP_AP_BIT])
    begin
      bank_open_reg[cmd_s2_reg.ba] <= 1'b0;
    end
  end

  logic [2:0] cl_reg;
  logic [2:0] al_reg;
  logic       bl8_reg;
  logic       diff_reg;
  logic [3:0] bl_val;
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      cl_reg   <= `DDRP_CL_RST;
      al_reg   <= `DDRP_AL_RST;
      bl8_reg  <= 1'b0;
      diff_reg <= 1'b0;
    end
    else if (mrs_take && cmd_s2_reg.ba == `DDRP_BA_MR)
    begin
      cl_reg  <= cmd_s2_reg.addr[`DDRP_CL_LSB +: 3];
      bl8_reg <= (cmd_s2_reg.addr[`DDRP_BL_LSB +: 3] == `DDRP_BL8_CODE);
    end
    else if (mrs_take && cmd_s2_reg.ba == `DDRP_BA_EMR1)
    begin
      al_reg   <= cmd_s2_reg.addr[`DDRP_AL_LSB +: 3];
      diff_reg <= !cmd_s2_reg.addr[`DDRP_DIFF_BIT];
    end
  end
  assign bl_val = bl8_reg ? `DDRP_BL8 : `DDRP_BL4;

  function automatic logic [8:0] burst_col(input logic [8:0] base, input logic [3:0] i,
                                           input logic bl8);
    burst_col = bl8 ? {base[8:3], base[2:0] + i[2:0]} : {base[8:2], base[1:0] + i[1:0]};
  endfunction

  logic [15:0] mem [1 << MAW];

  // Read fetch fills the FIFO; its ready stalls the fetch when full
  logic [3:0]  fetch_cnt_reg;
  logic [1:0]  acc_ba_reg;
  logic [12:0] acc_row_reg;
  logic [8:0]  acc_col_reg;
  logic [8:0]  fetch_col;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        rd_pop;
  logic [15:0] fifo_head;
  logic        fetch_push;
  assign fetch_col  = burst_col(acc_col_reg, bl_val - fetch_cnt_reg, bl8_reg);
  assign fetch_push = (fetch_cnt_reg != 4'h0);

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      fetch_cnt_reg <= 4'h0;
    end
    else if (rd_take)
    begin
      fetch_cnt_reg <= bl_val;
    end
    else if (fetch_push && fifo_in_ready)
    begin
      fetch_cnt_reg <= fetch_cnt_reg - 4'h1;
    end
  end

  ddrp_fifo #(
    .W (16),
    .D (`DDRP_FIFO_D)
  ) u_rd_fifo (
    .clk_in        (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (fetch_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (mem[{acc_ba_reg, acc_row_reg[ROW_BITS-1:0], fetch_col[COL_BITS-1:0]}]),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (rd_pop),
    .out_data_out  (fifo_head)
  );

  always_ff @(posedge clk_sys_in)
  begin
    if (rd_take || wr_take)
    begin
      acc_ba_reg  <= cmd_s2_reg.ba;
      acc_row_reg <= bank_row_reg[cmd_s2_reg.ba];
      acc_col_reg <= cmd_s2_reg.addr[8:0];
    end
  end

  // Read burst: wait RL clock rises, then one beat on every clock edge
  logic [3:0]  rl_cnt_reg;
  logic [3:0]  beat_cnt_reg;
  logic        rd_oe_n_reg;
  logic        dqs_reg;
  logic [15:0] dq_reg;
  // Beat zero leaves on the RL-th rise itself, so the strobe opens with a rising edge
  assign rd_pop = ((rd_state_reg == ddrp_pkg::RD_BURST && (ck_rise || ck_fall))
                   || (rd_state_reg == ddrp_pkg::RD_WAIT && ck_rise && rl_cnt_reg == 4'h1))
                  && (beat_cnt_reg != bl_val) && fifo_out_valid;

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      rd_state_reg <= ddrp_pkg::RD_IDLE;
      rl_cnt_reg   <= 4'h0;
      beat_cnt_reg <= 4'h0;
      rd_oe_n_reg  <= 1'b1;
      dqs_reg      <= 1'b0;
      dq_reg       <= 16'h0000;
    end
    else
    begin
      case (rd_state_reg)
        ddrp_pkg::RD_IDLE:
        begin
          if (rd_take)
          begin
            rl_cnt_reg   <= {1'b0, al_reg} + {1'b0, cl_reg};
            beat_cnt_reg <= 4'h0;
            rd_state_reg <= ddrp_pkg::RD_WAIT;
          end
        end
        ddrp_pkg::RD_WAIT:
        begin
          if (rd_pop)
          begin
            dq_reg       <= fifo_head;
            dqs_reg      <= 1'b1;
            rd_oe_n_reg  <= 1'b0;
            beat_cnt_reg <= beat_cnt_reg + 4'h1;
          end
          if (ck_rise)
          begin
            rl_cnt_reg <= rl_cnt_reg - 4'h1;
            if (rl_cnt_reg == 4'h1)
            begin
              rd_state_reg <= ddrp_pkg::RD_BURST;
            end
          end
        end
        ddrp_pkg::RD_BURST:
        begin
          if (rd_pop)
          begin
            dq_reg       <= fifo_head;
            dqs_reg      <= ck_rise;
            rd_oe_n_reg  <= 1'b0;
            beat_cnt_reg <= beat_cnt_reg + 4'h1;
          end
          else if ((ck_rise || ck_fall) && beat_cnt_reg == bl_val)
          begin
            rd_oe_n_reg  <= 1'b1;
            dqs_reg      <= 1'b0;
            rd_state_reg <= ddrp_pkg::RD_IDLE;
          end
        end
        default:
        begin
          rd_state_reg <= ddrp_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Write capture: each lane samples data and mask on both edges of its own strobe
  logic [1:0]  hold_v;
  logic [15:0] merged;
  logic [3:0]  wcnt_reg;
  logic [MAW-1:0] widx;
  logic [8:0]  wr_col;
  logic        commit;
  assign wr_col = burst_col(acc_col_reg, wcnt_reg, bl8_reg);
  assign widx   = {acc_ba_reg, acc_row_reg[ROW_BITS-1:0], wr_col[COL_BITS-1:0]};
  assign commit = wr_act_reg && (&hold_v);

  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    logic [7:0] byte_reg;
    logic       mask_reg;
    logic       v_reg;
    logic       edge_seen;
    assign edge_seen = wr_act_reg && (dqs_s2_reg[g] ^ dqs_s3_reg[g]);
    always_ff @(posedge clk_sys_in)
    begin
      if (!reset_n_in)
      begin
        v_reg <= 1'b0;
      end
      else if (edge_seen)
      begin
        byte_reg <= dq_s2_reg[8*g +: 8];
        mask_reg <= dm_s2_reg[g];
        v_reg    <= 1'b1;
      end
      else if (commit || !wr_act_reg)
      begin
        v_reg <= 1'b0;
      end
    end
    assign hold_v[g]       = v_reg;
    assign merged[8*g +: 8] = mask_reg ? mem[widx][8*g +: 8] : byte_reg;
    assign dq_oe_n_out[8*g +: 8] = {8{rd_oe_n_reg}};
    assign dqs_oe_n_out[g]       = rd_oe_n_reg;
    assign dqs_n_oe_n_out[g]     = rd_oe_n_reg || !diff_reg;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      wr_act_reg <= 1'b0;
      wcnt_reg   <= 4'h0;
    end
    else if (wr_take)
    begin
      wr_act_reg <= 1'b1;
      wcnt_reg   <= 4'h0;
    end
    else if (commit)
    begin
      wcnt_reg <= wcnt_reg + 4'h1;
      if (wcnt_reg == bl_val - 4'h1)
      begin
        wr_act_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (commit)
    begin
      mem[widx] <= merged;
    end
  end

  assign dq_out    = dq_reg;
  assign dqs_out   = {2{dqs_reg}};
  assign dqs_n_out = {2{!dqs_reg}};

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  cs_ignore_a: assert property ((bank_open_reg & ~$past(bank_open_reg)) != 4'h0
    |-> $past(ck_rise && clk_on_reg && !cmd_s2_reg.cs_n))
    else $error("bank opened without a selected command");
  row_latch_a: assert property (act_take
    |=> bank_open_reg[$past(cmd_s2_reg.ba)] && bank_row_reg[$past(cmd_s2_reg.ba)] == $past(cmd_s2_reg.addr))
    else $error("activate did not latch the row");
  ap_close_a: assert property ((rd_take || wr_take) && cmd_s2_reg.addr[`DDRP_AP_BIT]
    |=> !bank_open_reg[$past(cmd_s2_reg.ba)])
    else $error("auto-precharge left bank open");
  odt_follow_a: assert property ($changed(odt_on_out) |-> $past(ck_rise))
    else $error("termination changed off a clock rise");
  beat_edge_a: assert property ($changed(dq_out) |-> $past(ck_rise || ck_fall))
    else $error("read data changed off a clock edge");
  strobe_align_a: assert property (rd_pop |=> dqs_reg == $past(ck_rise) && !dqs_oe_n_out[0])
    else $error("read strobe not aligned with data");
  diff_off_a: assert property (!diff_reg |-> dqs_n_oe_n_out == 2'h3)
    else $error("complement strobe driven in single-ended mode");
  mask_keep_a: assert property (commit && g_lane[0].mask_reg
    |=> mem[$past(widx)][7:0] == $past(mem[widx][7:0]))
    else $error("masked byte was written");
  burst_len_a: assert property ($fell(rd_state_reg == ddrp_pkg::RD_BURST)
    |-> $past(beat_cnt_reg) == bl_val)
    else $error("read burst length wrong");
  latency_a: assert property (rd_take |=> rl_cnt_reg == {1'b0, al_reg} + {1'b0, cl_reg})
    else $error("read latency not loaded");

  read_burst_c: cover property (rd_pop && beat_cnt_reg == `DDRP_BL8 - 4'h1);
  write_commit_c: cover property (commit && wcnt_reg == bl_val - 4'h1);
  masked_beat_c: cover property (commit && g_lane[1].mask_reg);
endmodule

/* design/ddrp_cfg.svh */
`ifndef DDRP_CFG_SVH
`define DDRP_CFG_SVH
`define DDRP_ROW_W     13
`define DDRP_COL_W     9
`define DDRP_BA_W      2
`define DDRP_DQ_W      16
`define DDRP_AP_BIT    10
`define DDRP_CMD_ACT   3'h3
`define DDRP_CMD_RD    3'h5
`define DDRP_CMD_WR    3'h4
`define DDRP_CMD_PRE   3'h2
`define DDRP_CMD_MRS   3'h0
`define DDRP_BA_MR     2'h0
`define DDRP_BA_EMR1   2'h1
`define DDRP_BL_LSB    0
`define DDRP_BL8_CODE  3'h3
`define DDRP_CL_LSB    4
`define DDRP_AL_LSB    3
`define DDRP_DIFF_BIT  10
`define DDRP_CL_RST    3'h3
`define DDRP_AL_RST    3'h0
`define DDRP_BL4       4'h4
`define DDRP_BL8       4'h8
`define DDRP_FIFO_D    8
`endif

/* design/ddrp_pkg.sv */
package ddrp_pkg;
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
  } ddrp_cmd_s;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} ddrp_rd_e;
endpackage

/* verif/ddrp_ctrl_model.sv */
`timescale 1ns/1ps
`include "ddrp_cfg.svh"
module ddrp_ctrl_model (
  input  wire logic           clk_sys_in, // System clock
  input  wire logic           reset_n_in, // Active low reset
  output ddrp_pkg::ddrp_cmd_s cmd_out,    // Command, bank and address
  output logic                ck_out,     // Memory clock, 80 ns
  output logic                cke_out,    // Clock enable
  output logic                odt_out,    // Termination request
  output logic [1:0]          dm_out,     // Write masks
  output logic [15:0]         dq_out,     // Write data
  output logic [1:0]          dqs_out,    // Write strobes
  output logic                drv_out,    // High while writing
  input  wire logic [15:0]    q_in,       // Device data
  input  wire logic [15:0]    q_oe_n_in,  // Device data enable
  input  wire logic [1:0]     s_in,       // Device strobe
  input  wire logic [1:0]     s_oe_n_in,  // Device strobe enable
  input  wire logic [1:0]     sn_in,      // Device complement strobe
  input  wire logic [1:0]     sn_oe_n_in  // Device complement enable
);
  logic [1:0]  ph;
  logic [1:0]  s_prev;
  logic [15:0] q_prev;
  logic        on_prev;
  logic [15:0] beats [$];
  int          cyc;
  int          cmd_cyc;
  int          first_cyc;
  int          last_cyc;
  int          align_bad;
  int          lane_bad;
  int          diff_seen;
  int          diff_bad;

  initial
  begin
    cmd_out = {4'hF, 2'h0, 13'h0000};
    {ck_out, cke_out, odt_out, drv_out, ph} = 6'h00;
    {dm_out, dqs_out, dq_out} = 20'h00000;
    {cyc, align_bad, lane_bad, diff_bad, on_prev, s_prev} = '0;
  end

  // Clock runs free, as a real controller's does
  always @(posedge clk_sys_in)
  begin
    ph <= reset_n_in ? ph + 2'h1 : 2'h0;
    if (!reset_n_in)
      ck_out <= 1'b0;
    else if (ph == 2'h3)
      ck_out <= ~ck_out;
  end

  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (s_oe_n_in === 2'h0)
    begin
      if (s_in !== s_prev)
      begin
        if (beats.size() == 0)
          first_cyc = cyc;
        last_cyc = cyc;
        beats.push_back(q_in);
      end
      else if (on_prev && q_in !== q_prev)
        align_bad++;
      if (sn_oe_n_in === 2'h0)
      begin
        diff_seen++;
        if (sn_in !== ~s_in)
          diff_bad++;
      end
    end
    if (q_oe_n_in !== {{8{s_oe_n_in[1]}}, {8{s_oe_n_in[0]}}})
      lane_bad++;
    s_prev <= s_in;
    q_prev <= q_in;
    on_prev <= (s_oe_n_in === 2'h0);
  end

  // Returns at the clk_sys edge on which ck leaves level lvl
  task automatic edge_wait(input logic lvl);
    @(posedge clk_sys_in);
    while (!(ck_out === lvl && ph == 2'h3))
      @(posedge clk_sys_in);
  endtask

  // Pins change at ck fall, so they stand 40 ns either side of the rise
  task automatic cmd(input logic [3:0] code, input logic [1:0] ba, input logic [12:0] a);
    edge_wait(1'b1);
    cmd_out <= {code, ba, a};
    edge_wait(1'b0);
    cmd_cyc = cyc;
    edge_wait(1'b1);
    cmd_out <= {4'hF, ba, a};
  endtask

  task automatic pins(input logic e, input logic o);
    edge_wait(1'b1);
    cke_out <= e;
    odt_out <= o;
  endtask

  // Strobe edge sits mid-beat, 40 ns after the data changes
  task automatic wr(input logic [1:0] ba, input logic [12:0] a, input int n,
                    input logic [15:0] d [8], input logic [1:0] m [8]);
    drv_out <= 1'b1;
    dqs_out <= 2'h0;
    cmd({1'b0, `DDRP_CMD_WR}, ba, a);
    for (int k = 0; k < n; k++)
    begin
      dq_out <= d[k];
      dm_out <= m[k];
      repeat (4) @(posedge clk_sys_in);
      dqs_out <= ~dqs_out;
      repeat (4) @(posedge clk_sys_in);
    end
    drv_out <= 1'b0;
    // Lets an edge pass so a following write never sets drv_out in this same step
    @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [1:0] ba, input logic [12:0] a, input logic cs_n, input int n);
    int t;
    t = 0;
    beats.delete();
    diff_seen = 0;
    cmd({cs_n, `DDRP_CMD_RD}, ba, a);
    while (t < 150 && (n == 0 || beats.size() < n))
    begin
      @(posedge clk_sys_in);
      t++;
    end
    // Extra beats of a too long burst would land here
    repeat (24) @(posedge clk_sys_in);
  endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`include "ddrp_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
  logic                clk;
  logic                rst_n;
  logic [15:0]         junk;
  ddrp_pkg::ddrp_cmd_s cmd;
  logic                ck;
  logic                cke;
  logic                odt;
  logic                drv;
  logic [1:0]          dm;
  logic [15:0]         c_dq;
  logic [1:0]          c_dqs;
  logic [15:0]         d_dq;
  logic [15:0]         d_dq_oe_n;
  logic [1:0]          d_dqs;
  logic [1:0]          d_dqs_oe_n;
  logic [1:0]          d_dqs_n;
  logic [1:0]          d_dqs_n_oe_n;
  logic                odt_on;
  logic                clk_on;
  logic [15:0]         dq_bus;
  logic [1:0]          dqs_bus;
  logic [1:0]          wm [8];
  int                  err_total;
  int                  checked;

  // Undriven lines show a changing pattern, never the last value
  assign dq_bus = drv ? c_dq : ((d_dq & ~d_dq_oe_n) | (junk & d_dq_oe_n));
  assign dqs_bus = drv ? c_dqs : ((d_dqs & ~d_dqs_oe_n) | (junk[1:0] & d_dqs_oe_n));

  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) junk <= ~junk;

  ddrp_ctrl_model u_ddrp_ctrl_model (
    .clk_sys_in(clk), .reset_n_in(rst_n), .cmd_out(cmd), .ck_out(ck), .cke_out(cke),
    .odt_out(odt), .dm_out(dm), .dq_out(c_dq), .dqs_out(c_dqs), .drv_out(drv),
    .q_in(d_dq), .q_oe_n_in(d_dq_oe_n), .s_in(d_dqs), .s_oe_n_in(d_dqs_oe_n),
    .sn_in(d_dqs_n), .sn_oe_n_in(d_dqs_n_oe_n));

  ddrp_device u_ddrp_device (
    .clk_sys_in(clk), .reset_n_in(rst_n), .ck_in(ck), .cke_in(cke), .cs_n_in(cmd.cs_n),
    .ras_n_in(cmd.ras_n), .cas_n_in(cmd.cas_n), .we_n_in(cmd.we_n), .ba_in(cmd.ba),
    .addr_in(cmd.addr), .odt_in(odt), .dm_in(dm), .dq_in(dq_bus), .dq_out(d_dq),
    .dq_oe_n_out(d_dq_oe_n), .dqs_in(dqs_bus), .dqs_out(d_dqs), .dqs_oe_n_out(d_dqs_oe_n),
    .dqs_n_out(d_dqs_n), .dqs_n_oe_n_out(d_dqs_n_oe_n), .odt_on_out(odt_on),
    .clk_on_out(clk_on));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic t_reset();
    `CHK("dq_oe_n", 16'hFFFF, d_dq_oe_n)
    `CHK("dqs_oe_n", 2'h3, d_dqs_oe_n)
    `CHK("odt_on", 1'b0, odt_on)
    `CHK("clk_on", 1'b0, clk_on)
  endtask

  task automatic t_pins();
    u_ddrp_ctrl_model.pins(1'b1, 1'b1);
    repeat (16) @(posedge clk);
    `CHK("clk_on", 1'b1, clk_on)
    `CHK("odt_on", 1'b1, odt_on)
    u_ddrp_ctrl_model.pins(1'b1, 1'b0);
    repeat (16) @(posedge clk);
    `CHK("odt_on", 1'b0, odt_on)
  endtask

  task automatic t_wr_rd();
    logic [15:0] a1 [8];
    logic [15:0] a2 [8];
    logic [15:0] nw [8];
    for (int k = 0; k < 8; k++)
    begin
      a1[k] = 16'hA050 + 16'h0101 * k;
      a2[k] = 16'h3C0F + 16'h0101 * k;
      nw[k] = 16'hC030 + 16'h0101 * k;
      wm[k] = 2'h0;
    end
    u_ddrp_ctrl_model.cmd({1'b0, `DDRP_CMD_ACT}, 2'h1, 13'h0002);
    u_ddrp_ctrl_model.cmd({1'b0, `DDRP_CMD_ACT}, 2'h2, 13'h0001);
    u_ddrp_ctrl_model.wr(2'h1, 13'h0004, 4, a1, wm);
    u_ddrp_ctrl_model.wr(2'h2, 13'h0004, 4, a2, wm);
    wm[1] = 2'h1;
    wm[2] = 2'h2;
    wm[3] = 2'h3;
    u_ddrp_ctrl_model.wr(2'h1, 13'h0004, 4, nw, wm);
    u_ddrp_ctrl_model.rd(2'h1, 13'h0004, 1'b0, 4);
    `CHK("beats", 4, u_ddrp_ctrl_model.beats.size())
    `CHK("latency", 1'b1, (u_ddrp_ctrl_model.first_cyc - u_ddrp_ctrl_model.cmd_cyc) inside {[25:31]})
    `CHK("span", 12, u_ddrp_ctrl_model.last_cyc - u_ddrp_ctrl_model.first_cyc)
    `CHK("beat0", nw[0], u_ddrp_ctrl_model.beats[0])
    `CHK("beat1", {nw[1][15:8], a1[1][7:0]}, u_ddrp_ctrl_model.beats[1])
    `CHK("beat2", {a1[2][15:8], nw[2][7:0]}, u_ddrp_ctrl_model.beats[2])
    `CHK("beat3", a1[3], u_ddrp_ctrl_model.beats[3])
    u_ddrp_ctrl_model.rd(2'h2, 13'h0006, 1'b0, 4);
    for (int k = 0; k < 4; k++)
      `CHK("wrap", a2[(k + 2) % 4], u_ddrp_ctrl_model.beats[k])
    `CHK("align", 0, u_ddrp_ctrl_model.align_bad)
    `CHK("lanes", 0, u_ddrp_ctrl_model.lane_bad)
    `CHK("single", 0, u_ddrp_ctrl_model.diff_seen)
  endtask

  task automatic t_ignore();
    u_ddrp_ctrl_model.rd(2'h1, 13'h0004, 1'b1, 0);
    `CHK("deselect", 0, u_ddrp_ctrl_model.beats.size())
    u_ddrp_ctrl_model.rd(2'h1, 13'h0404, 1'b0, 4);
    `CHK("ap_read", 4, u_ddrp_ctrl_model.beats.size())
    u_ddrp_ctrl_model.rd(2'h1, 13'h0004, 1'b0, 0);
    `CHK("closed", 0, u_ddrp_ctrl_model.beats.size())
    u_ddrp_ctrl_model.pins(1'b0, 1'b0);
    repeat (16) @(posedge clk);
    `CHK("clk_off", 1'b0, clk_on)
    u_ddrp_ctrl_model.rd(2'h2, 13'h0004, 1'b0, 0);
    `CHK("cke_low", 0, u_ddrp_ctrl_model.beats.size())
    u_ddrp_ctrl_model.pins(1'b1, 1'b0);
    repeat (16) @(posedge clk);
  endtask

  task automatic t_bl8();
    logic [15:0] nw [8];
    for (int k = 0; k < 8; k++)
    begin
      nw[k] = 16'h0F1E + 16'h1111 * k;
      wm[k] = 2'h0;
    end
    u_ddrp_ctrl_model.cmd({1'b0, `DDRP_CMD_MRS}, `DDRP_BA_MR, 13'h0043);
    u_ddrp_ctrl_model.cmd({1'b0, `DDRP_CMD_MRS}, `DDRP_BA_EMR1, 13'h0008);
    u_ddrp_ctrl_model.cmd({1'b0, `DDRP_CMD_ACT}, 2'h3, 13'h0000);
    u_ddrp_ctrl_model.wr(2'h3, 13'h0000, 8, nw, wm);
    u_ddrp_ctrl_model.rd(2'h3, 13'h0000, 1'b0, 8);
    `CHK("beats8", 8, u_ddrp_ctrl_model.beats.size())
    `CHK("latency5", 1'b1, (u_ddrp_ctrl_model.first_cyc - u_ddrp_ctrl_model.cmd_cyc) inside {[41:47]})
    `CHK("span8", 28, u_ddrp_ctrl_model.last_cyc - u_ddrp_ctrl_model.first_cyc)
    for (int k = 0; k < 8; k++)
      `CHK("bl8_data", nw[k], u_ddrp_ctrl_model.beats[k])
    `CHK("diff_on", 1'b1, u_ddrp_ctrl_model.diff_seen > 0)
    `CHK("diff_pol", 0, u_ddrp_ctrl_model.diff_bad)
  endtask

  initial
  begin
    rst_n = 1'b0;
    junk = 16'h5A5A;
    err_total = 0;
    checked = 0;
    // Four edges so the pin synchronisers flush as well
    repeat (4) @(posedge clk);
    t_reset();
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_pins();
    t_wr_rd();
    t_ignore();
    t_bl8();
    test_done();
  end

  initial
  begin
    #200000;
    err_total++;
    test_done();
  end
endmodule
